// File: verilog/felc_line_coder.sv
`timescale 1ns/100ps
module felc_line_coder #(
    parameter int FIFO_DEPTH = felc_pkg::FIFO_DEPTH,
    parameter int LOCK_RUN   = 16,
    parameter int LOSS_RUN   = 8
) (
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    input  wire logic       copperMode,
    input  wire logic [3:0] txNibble,
    input  wire logic       txEnable,
    input  wire logic       txError,
    output logic            txReady,
    output logic            lineTxBit,
    output logic [1:0]      lineTxLevel,
    input  wire logic       lineRxBit,
    output logic [3:0]      rxNibble,
    output logic            rxValid,
    output logic            rxError,
    output logic            rxInFrame
);
    felc_pkg::felc_tx_t txState_reg;
    logic [4:0]  encSym;
    logic        encValid;
    logic        encReady;
    logic [4:0]  symOut;
    logic        symValid;
    logic        symTake;
    logic [4:0]  shReg_reg;
    logic [2:0]  bitCnt_reg;
    logic [10:0] scr_reg;
    logic        serBit;
    logic        nrzi_reg;
    logic        mltUp_reg;
    logic        lineBit_reg;
    logic [1:0]  level_reg;

    localparam int LOCK_W = $clog2(LOCK_RUN);

    if (FIFO_DEPTH < 2) begin : g_badDepth
        $error("felc_line_coder: FIFO_DEPTH must be at least 2");
    end
    // A full key history needs eleven clean idle bits; an error group may legally follow four zeros
    if (LOCK_RUN < 12 || LOSS_RUN < 5 || LOSS_RUN > LOCK_RUN) begin : g_badRun
        $error("felc_line_coder: LOCK_RUN or LOSS_RUN out of range");
    end

    // Transmit framing: nibble request to code group
    always_comb begin
        encSym   = felc_pkg::SYM_IDLE;
        encValid = 1'b1;
        txReady  = 1'b0;
        unique case (txState_reg)
            felc_pkg::TX_IDLE: encSym = felc_pkg::SYM_IDLE;
            felc_pkg::TX_SSD1: encSym = felc_pkg::SYM_SSD1;
            felc_pkg::TX_SSD2: encSym = felc_pkg::SYM_SSD2;
            felc_pkg::TX_DATA: begin
                txReady = encReady && txEnable;
                encValid = txEnable;
                encSym  = txError ? felc_pkg::SYM_TXER : felc_pkg::enc4b5b(txNibble);
            end
            felc_pkg::TX_ESD1: encSym = felc_pkg::SYM_ESD1;
            felc_pkg::TX_ESD2: encSym = felc_pkg::SYM_ESD2;
            default: encSym = felc_pkg::SYM_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            txState_reg <= felc_pkg::TX_IDLE;
        end else if (encReady) begin
            unique case (txState_reg)
                felc_pkg::TX_IDLE: if (txEnable) txState_reg <= felc_pkg::TX_SSD1;
                felc_pkg::TX_SSD1: txState_reg <= felc_pkg::TX_SSD2;
                felc_pkg::TX_SSD2: txState_reg <= felc_pkg::TX_DATA;
                felc_pkg::TX_DATA: if (!txEnable) txState_reg <= felc_pkg::TX_ESD1;
                felc_pkg::TX_ESD1: txState_reg <= felc_pkg::TX_ESD2;
                felc_pkg::TX_ESD2: txState_reg <= felc_pkg::TX_IDLE;
                default: txState_reg <= felc_pkg::TX_IDLE;
            endcase
        end
    end

    // Symbols queue ahead of the serialiser, which drains one bit per clock
    felc_fifo #(
        .WIDTH (felc_pkg::SYM_W),
        .DEPTH (FIFO_DEPTH)
    ) uTxFifo (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .inData   (encSym),
        .inValid  (encValid),
        .inReady  (encReady),
        .outData  (symOut),
        .outValid (symValid),
        .outReady (symTake)
    );

    assign symTake = (bitCnt_reg == felc_pkg::BIT_LAST);

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            shReg_reg  <= felc_pkg::SYM_IDLE;
            bitCnt_reg <= felc_pkg::BIT_LAST;
        end else if (symTake) begin
            shReg_reg  <= symValid ? symOut : felc_pkg::SYM_IDLE;
            bitCnt_reg <= '0;
        end else begin
            shReg_reg  <= {shReg_reg[3:0], 1'b0};
            bitCnt_reg <= bitCnt_reg + 3'h1;
        end
    end

    // Side-stream scrambler, x^11 + x^9 + 1
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            scr_reg <= felc_pkg::SCR_SEED;
        end else begin
            scr_reg <= {scr_reg[9:0], scr_reg[10] ^ scr_reg[8]};
        end
    end

    assign serBit = copperMode ? (shReg_reg[4] ^ scr_reg[10]) : shReg_reg[4];

    // NRZI level and three-level sequencer
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            nrzi_reg  <= 1'b0;
            mltUp_reg <= 1'b1;
            level_reg <= felc_pkg::LVL_MID;
        end else if (serBit) begin
            nrzi_reg <= ~nrzi_reg;
            unique case (level_reg)
                felc_pkg::LVL_LOW: begin
                    level_reg <= felc_pkg::LVL_MID;
                    mltUp_reg <= 1'b1;
                end
                felc_pkg::LVL_HIGH: begin
                    level_reg <= felc_pkg::LVL_MID;
                    mltUp_reg <= 1'b0;
                end
                felc_pkg::LVL_MID: level_reg <= mltUp_reg ? felc_pkg::LVL_HIGH : felc_pkg::LVL_LOW;
                default: level_reg <= felc_pkg::LVL_MID;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            lineBit_reg <= 1'b0;
        end else begin
            lineBit_reg <= nrzi_reg;
        end
    end

    assign lineTxBit   = lineBit_reg;
    assign lineTxLevel = copperMode ? level_reg : felc_pkg::LVL_MID;

    // Receive: NRZI decode, descramble, align on the start pair
    felc_pkg::felc_rx_t rxState_reg;
    logic        rxPrev_reg;
    logic        rxRaw;
    logic [10:0] dscr_reg;
    logic        rxBit;
    logic [3:0]  rxHist_reg;
    logic        dscrKey;
    logic        descBit;
    logic        scrLock_reg;
    logic [LOCK_W-1:0] lockRun_reg;
    logic [2:0]  rxCnt_reg;
    logic [4:0]  rxSym;
    logic        rxSymStb;
    logic [4:0]  rxDec;
    logic [3:0]  rxNib_reg;
    logic        rxVal_reg;
    logic        rxErr_reg;

    assign rxRaw = lineRxBit ^ rxPrev_reg;

    // Key is loaded from the line while unlocked, idle being all ones before scrambling;
    // once locked the register runs on its own feedback
    assign dscrKey = dscr_reg[10] ^ dscr_reg[8];
    assign descBit = rxRaw ^ dscrKey;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rxPrev_reg <= 1'b0;
            dscr_reg   <= '0;
        end else begin
            rxPrev_reg <= lineRxBit;
            dscr_reg   <= {dscr_reg[9:0], scrLock_reg ? dscrKey : ~rxRaw};
        end
    end

    // Lock on a run of clean idle bits; drop it on a zero run that no coded stream holds
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            lockRun_reg <= '0;
            scrLock_reg <= 1'b0;
        end else if (!copperMode) begin
            lockRun_reg <= '0;
            scrLock_reg <= 1'b0;
        end else if (!scrLock_reg) begin
            if (!descBit) begin
                lockRun_reg <= '0;
            end else if (lockRun_reg == LOCK_W'(LOCK_RUN - 1)) begin
                lockRun_reg <= '0;
                scrLock_reg <= 1'b1;
            end else begin
                lockRun_reg <= lockRun_reg + 1'b1;
            end
        end else begin
            if (descBit) begin
                lockRun_reg <= '0;
            end else if (lockRun_reg == LOCK_W'(LOSS_RUN - 1)) begin
                lockRun_reg <= '0;
                scrLock_reg <= 1'b0;
            end else begin
                lockRun_reg <= lockRun_reg + 1'b1;
            end
        end
    end

    // Unlocked copper input reads as idle so no frame opens on noise
    assign rxBit = copperMode ? (scrLock_reg ? descBit : 1'b1) : rxRaw;
    assign rxSym = {rxHist_reg[3:0], rxBit};
    assign rxSymStb = (rxState_reg == felc_pkg::RX_HUNT) ? 1'b0 : (rxCnt_reg == felc_pkg::BIT_LAST);
    assign rxDec = felc_pkg::dec5b4b(rxSym);

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rxHist_reg <= '0;
            rxCnt_reg  <= '0;
            rxState_reg <= felc_pkg::RX_HUNT;
        end else begin
            rxHist_reg <= {rxHist_reg[2:0], rxBit};
            rxCnt_reg  <= (rxCnt_reg == felc_pkg::BIT_LAST) ? 3'h0 : rxCnt_reg + 3'h1;
            unique case (rxState_reg)
                felc_pkg::RX_HUNT: if (rxSym == felc_pkg::SYM_SSD1) begin
                    rxState_reg <= felc_pkg::RX_SSD2;
                    rxCnt_reg   <= '0;
                end
                felc_pkg::RX_SSD2: if (rxSymStb) begin
                    rxState_reg <= (rxSym == felc_pkg::SYM_SSD2) ? felc_pkg::RX_FRAME : felc_pkg::RX_HUNT;
                end
                felc_pkg::RX_FRAME: if (rxSymStb && (rxSym == felc_pkg::SYM_ESD2 || rxSym == felc_pkg::SYM_IDLE)) begin
                    rxState_reg <= felc_pkg::RX_HUNT;
                end
                default: rxState_reg <= felc_pkg::RX_HUNT;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rxNib_reg <= '0;
            rxVal_reg <= 1'b0;
            rxErr_reg <= 1'b0;
        end else begin
            rxVal_reg <= 1'b0;
            rxErr_reg <= 1'b0;
            if (rxState_reg == felc_pkg::RX_SSD2 && rxSymStb && rxSym == felc_pkg::SYM_SSD2) begin
                rxNib_reg <= felc_pkg::SSD_NIBBLE;
            end else if (rxState_reg == felc_pkg::RX_FRAME && rxSymStb) begin
                if (rxDec[4]) begin
                    rxNib_reg <= rxDec[3:0];
                    rxVal_reg <= 1'b1;
                end else if (rxSym != felc_pkg::SYM_ESD1 && rxSym != felc_pkg::SYM_ESD2
                             && rxSym != felc_pkg::SYM_IDLE) begin
                    rxErr_reg <= 1'b1;
                end
            end
        end
    end

    assign rxNibble  = rxNib_reg;
    assign rxValid   = rxVal_reg;
    assign rxError   = rxErr_reg;
    assign rxInFrame = (rxState_reg == felc_pkg::RX_FRAME);
endmodule : felc_line_coder

// File: inc/felc_pkg.sv
package felc_pkg;
    localparam int NIB_W = 4;
    localparam int SYM_W = 5;
    localparam int FIFO_DEPTH = 8;
    localparam logic [4:0] SYM_IDLE = 5'h1F;
    localparam logic [4:0] SYM_SSD1 = 5'h18;
    localparam logic [4:0] SYM_SSD2 = 5'h11;
    localparam logic [4:0] SYM_ESD1 = 5'h0D;
    localparam logic [4:0] SYM_ESD2 = 5'h07;
    localparam logic [4:0] SYM_TXER = 5'h04;
    localparam logic [3:0] SSD_NIBBLE = 4'h5;
    localparam logic [2:0] BIT_LAST = 3'h4;
    localparam logic [10:0] SCR_SEED = 11'h7FF;
    // Line levels: low, middle, high
    localparam logic [1:0] LVL_LOW = 2'h0;
    localparam logic [1:0] LVL_MID = 2'h1;
    localparam logic [1:0] LVL_HIGH = 2'h2;
    typedef enum logic [2:0] {TX_IDLE, TX_SSD1, TX_SSD2, TX_DATA, TX_ESD1, TX_ESD2} felc_tx_t;
    typedef enum logic [1:0] {RX_HUNT, RX_SSD2, RX_FRAME} felc_rx_t;

    function automatic logic [4:0] enc4b5b(input logic [3:0] n);
        logic [4:0] s;
        s = SYM_IDLE;
        unique case (n)
            4'h0: s = 5'h1E;
            4'h1: s = 5'h09;
            4'h2: s = 5'h14;
            4'h3: s = 5'h15;
            4'h4: s = 5'h0A;
            4'h5: s = 5'h0B;
            4'h6: s = 5'h0E;
            4'h7: s = 5'h0F;
            4'h8: s = 5'h12;
            4'h9: s = 5'h13;
            4'hA: s = 5'h16;
            4'hB: s = 5'h17;
            4'hC: s = 5'h1A;
            4'hD: s = 5'h1B;
            4'hE: s = 5'h1C;
            4'hF: s = 5'h1D;
        endcase
        return s;
    endfunction : enc4b5b

    // Returns {valid, nibble}; valid low for control and invalid groups
    function automatic logic [4:0] dec5b4b(input logic [4:0] s);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 0; i < 16; i++) begin
            if (enc4b5b(4'(i)) == s) begin
                r = {1'b1, 4'(i)};
            end
        end
        return r;
    endfunction : dec5b4b
endpackage : felc_pkg

// File: verilog/felc_fifo.sv
`timescale 1ns/100ps
module felc_fifo #(
    parameter int WIDTH = 5,
    parameter int DEPTH = 8
) (
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic      [WIDTH-1:0] outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);
    if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH) begin : g_badShape
        $error("felc_fifo: WIDTH must be at least 1 and DEPTH a power of two >= 2");
    end
    logic [WIDTH-1:0] memArr [DEPTH];
    logic [AW:0]      wrPtr_reg;
    logic [AW:0]      rdPtr_reg;
    logic             doWr;
    logic             doRd;

    assign inReady  = (wrPtr_reg - rdPtr_reg) != (AW+1)'(DEPTH);
    assign outValid = wrPtr_reg != rdPtr_reg;
    assign outData  = memArr[rdPtr_reg[AW-1:0]];
    assign doWr     = inValid && inReady;
    assign doRd     = outValid && outReady;

    always_ff @(posedge core_clk) begin
        if (doWr) begin
            memArr[wrPtr_reg[AW-1:0]] <= inData;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
        end else begin
            if (doWr) wrPtr_reg <= wrPtr_reg + 1'b1;
            if (doRd) rdPtr_reg <= rdPtr_reg + 1'b1;
        end
    end
endmodule : felc_fifo

// File: dv/felc_line_coder_assertions.sv
`timescale 1ns/100ps
module felc_line_coder_assertions (
    input wire logic       core_clk,
    input wire logic       sys_rst,
    input wire logic       copperMode,
    input wire logic       txEnable,
    input wire logic       txReady,
    input wire logic [1:0] lineTxLevel,
    input wire logic       rxValid,
    input wire logic       rxError,
    input wire logic       rxInFrame
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    logic lastHigh_reg;
    // Last extreme visited by the line
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            lastHigh_reg <= 1'b0;
        end else if (lineTxLevel != felc_pkg::LVL_MID) begin
            lastHigh_reg <= lineTxLevel == felc_pkg::LVL_HIGH;
        end
    end
    property p_lvlLegal; lineTxLevel != 2'h3; endproperty
    a_lvlLegal: assert property (p_lvlLegal) else $error("illegal line level");
    property p_fiberMid; !copperMode [*3] |-> lineTxLevel == felc_pkg::LVL_MID; endproperty
    a_fiberMid: assert property (p_fiberMid) else $error("fiber level not middle");
    property p_lowStep; lineTxLevel == felc_pkg::LVL_LOW |=> lineTxLevel != felc_pkg::LVL_HIGH; endproperty
    a_lowStep: assert property (p_lowStep) else $error("low jumped to high");
    property p_highStep; lineTxLevel == felc_pkg::LVL_HIGH |=> lineTxLevel != felc_pkg::LVL_LOW; endproperty
    a_highStep: assert property (p_highStep) else $error("high jumped to low");
    property p_midDir; copperMode && $past(lineTxLevel) == felc_pkg::LVL_MID && lineTxLevel != felc_pkg::LVL_MID
        |-> lineTxLevel == (lastHigh_reg ? felc_pkg::LVL_LOW : felc_pkg::LVL_HIGH); endproperty
    a_midDir: assert property (p_midDir) else $error("middle level left the wrong way");
    property p_validGap; rxValid |=> !rxValid [*4]; endproperty
    a_validGap: assert property (p_validGap) else $error("nibbles closer than a group");
    property p_errGap; rxError |=> !rxError [*4]; endproperty
    a_errGap: assert property (p_errGap) else $error("errors closer than a group");
    property p_validInFrame; rxValid |-> rxInFrame; endproperty
    a_validInFrame: assert property (p_validInFrame) else $error("nibble outside frame");
    property p_validNoErr; rxValid |-> !rxError; endproperty
    a_validNoErr: assert property (p_validNoErr) else $error("nibble with error");
    property p_readyIdle; !txEnable [*8] |-> !txReady; endproperty
    a_readyIdle: assert property (p_readyIdle) else $error("ready while idle");
endmodule : felc_line_coder_assertions
bind felc_line_coder felc_line_coder_assertions u_felc_line_coder_assertions (
    .core_clk(core_clk), .sys_rst(sys_rst), .copperMode(copperMode), .txEnable(txEnable),
    .txReady(txReady), .lineTxLevel(lineTxLevel), .rxValid(rxValid), .rxError(rxError),
    .rxInFrame(rxInFrame)
);

// File: dv/felc_line_model.sv
`timescale 1ns/100ps
module felc_line_model (
    input  wire logic core_clk,
    input  wire logic sys_rst,
    input  wire logic lineTxBit,
    output logic      lineRxBit
);
    logic bitQ[$];
    // Queued groups override the loopback path
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            lineRxBit <= 1'b0;
        end else if (bitQ.size() > 0) begin
            lineRxBit <= lineRxBit ^ bitQ.pop_front();
        end else begin
            lineRxBit <= lineTxBit;
        end
    end
    task automatic pushSym(input logic [4:0] s);
        for (int i = 4; i >= 0; i--) begin
            bitQ.push_back(s[i]);
        end
    endtask : pushSym
endmodule : felc_line_model

// File: dv/felc_line_coder_tb_top.sv
`timescale 1ns/100ps
module felc_line_coder_tb_top;
    typedef struct packed {logic err; logic [3:0] nib; logic [4:0] sym;} felc_row_t;
    localparam logic [4:0] CODES [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
                                          5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
    localparam logic [4:0] BAD [10] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08, 5'h0C, 5'h10, 5'h19};
    felc_row_t  rows [17];
    logic       core_clk = 1'b0;
    logic       sys_rst;
    logic       copperMode;
    logic [3:0] txNibble;
    logic       txEnable;
    logic       txError;
    logic       txReady, lineTxBit, lineRxBit, rxValid, rxError, rxInFrame;
    logic       prevBit = 1'b0;
    logic [1:0] lineTxLevel, prevLvl;
    logic [3:0] rxNibble;
    logic       bitQ[$];
    logic [3:0] nibQ[$];
    int         num_errors = 0, checks_done = 0, errCount = 0, cycles = 0;
    int         stalls = 0, lvlMoves = 0, bitMoves = 0, pos;
    always #5 core_clk = ~core_clk;
    felc_line_coder u_felc_line_coder (
        .core_clk(core_clk), .sys_rst(sys_rst), .copperMode(copperMode), .txNibble(txNibble),
        .txEnable(txEnable), .txError(txError), .txReady(txReady), .lineTxBit(lineTxBit),
        .lineTxLevel(lineTxLevel), .lineRxBit(lineRxBit), .rxNibble(rxNibble),
        .rxValid(rxValid), .rxError(rxError), .rxInFrame(rxInFrame)
    );
    felc_line_model u_felc_line_model (
        .core_clk(core_clk), .sys_rst(sys_rst), .lineTxBit(lineTxBit), .lineRxBit(lineRxBit)
    );
    task automatic test_done();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    function automatic logic [4:0] grp(input int p);
        return {bitQ[p], bitQ[p+1], bitQ[p+2], bitQ[p+3], bitQ[p+4]};
    endfunction : grp
    task automatic sendFrame(input int n);
        int i;
        i = 0;
        txEnable = 1'b1;
        while (i < n) begin
            txNibble = rows[i].nib;
            txError = rows[i].err;
            #1;
            if (txReady) i++;
            else stalls++;
            @(negedge core_clk);
        end
        txEnable = 1'b0;
        txError = 1'b0;
    endtask : sendFrame
    // Line groups seen after NRZI decoding, receive results and timeout
    always @(posedge core_clk) begin
        if (!sys_rst) begin
            bitQ.push_back(lineTxBit ^ prevBit);
            if (rxValid) nibQ.push_back(rxNibble);
            if (rxError) errCount++;
            lvlMoves += int'(copperMode && lineTxLevel != prevLvl);
            bitMoves += int'(copperMode && lineTxBit != prevBit);
        end
        prevBit = lineTxBit;
        prevLvl = lineTxLevel;
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            test_done();
        end
    end
    initial begin
        sys_rst = 1'b1;
        copperMode = 1'b0;
        txNibble = 4'h0;
        txEnable = 1'b0;
        txError = 1'b0;
        for (int i = 0; i < 16; i++) rows[i] = '{1'b0, 4'(i), CODES[i]};
        rows[16] = '{1'b1, 4'h3, 5'h04};
        repeat (6) @(negedge core_clk);
        check(8'({lineTxBit, lineTxLevel, rxValid, rxError, rxInFrame}), 8'h08);
        sys_rst = 1'b0;
        repeat (10) @(negedge core_clk);
        sendFrame(17);
        check(8'(stalls > 4), 8'h01);
        wait (rxInFrame);
        wait (!rxInFrame);
        repeat (10) @(negedge core_clk);
        pos = 0;
        while (pos < 400 && !(grp(pos) === 5'h18 && grp(pos + 5) === 5'h11)) pos++;
        check(8'(grp(pos)), 8'h18);
        check(8'(grp(pos + 5)), 8'h11);
        for (int i = 0; i < 17; i++) check(8'(grp(pos + 10 + 5 * i)), 8'(rows[i].sym));
        check(8'(grp(pos + 95)), 8'h0D);
        check(8'(grp(pos + 100)), 8'h07);
        check(8'(grp(pos + 105)), 8'h1F);
        check(8'(nibQ.size()), 8'h10);
        for (int i = 0; i < 16; i++) check(8'(nibQ[i]), 8'(i));
        check(8'(errCount), 8'h01);
        nibQ.delete();
        errCount = 0;
        u_felc_line_model.pushSym(5'h18);
        u_felc_line_model.pushSym(5'h11);
        u_felc_line_model.pushSym(5'h0B);
        foreach (BAD[k]) u_felc_line_model.pushSym(BAD[k]);
        u_felc_line_model.pushSym(5'h0D);
        u_felc_line_model.pushSym(5'h07);
        u_felc_line_model.pushSym(5'h1F);
        wait (u_felc_line_model.bitQ.size() == 0);
        repeat (3) @(negedge core_clk);
        check(8'({nibQ.size() == 1, nibQ[0]}), 8'h15);
        check(8'(errCount), 8'h0A);
        check(8'(rxInFrame), 8'h00);
        sys_rst = 1'b1;
        copperMode = 1'b1;
        repeat (6) @(negedge core_clk);
        sys_rst = 1'b0;
        bitMoves = 0;
        lvlMoves = 0;
        nibQ.delete();
        errCount = 0;
        repeat (100) @(negedge core_clk);
        check(8'(bitMoves < 90), 8'h01);
        sendFrame(4);
        repeat (100) @(negedge core_clk);
        check(8'(nibQ.size()), 8'h04);
        for (int i = 0; i < 4; i++) check(8'(nibQ[i]), 8'(i));
        check(8'(errCount), 8'h00);
        check(8'(lvlMoves > 20), 8'h01);
        check(8'(lvlMoves + 1 >= bitMoves && lvlMoves <= bitMoves + 1), 8'h01);
        test_done();
    end
endmodule : felc_line_coder_tb_top
